// ==== verilog/mqer_readout.sv ====
// Motion, surface quality and exposure readout over the three-wire port.
// Assumes frame results arrive on clock; the serial port runs on sclk and
// the reader keeps sclk still while ncs_n is high.
`timescale 1ns/1ps
`default_nettype none
`include "mqer_consts.svh"

module mqer_readout
  import mqer_pkg::*;
(
  // Core clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Frame results
  input  wire mqer_frame_s frame,
  output var  logic [15:0] exposure_time,
  // Serial port
  input  wire logic        sclk,
  input  wire logic        ncs_n,
  input  wire logic        sdio_in,
  output var  logic        sdio_out,
  output var  logic        sdio_oe
);

  // ========================================================================
  // Crossing into the core domain
  logic       read_tog_reg;
  logic [6:0] read_addr_reg;
  logic [1:0] sync_q;
  logic       idle_s;
  logic       tog_s;

  mqer_sync #(.WIDTH(2)) u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in ({read_tog_reg, ncs_n}),
    .sync_out (sync_q)
  );

  assign idle_s = sync_q[0];
  assign tog_s  = sync_q[1];

  // ========================================================================
  // Core state
  logic signed [7:0] motion_y_reg;
  logic signed [7:0] motion_y_next;
  logic        [7:0] quality_reg;
  logic        [7:0] quality_next;
  logic       [15:0] exposure_next;
  logic              tog_seen_reg;
  logic              tog_seen_next;
  mqer_snap_s        snap_reg;
  mqer_snap_s        snap_next;
  logic              read_ev;
  logic              read_y;
  logic signed [9:0] y_sum;
  logic        [7:0] q_raw;
  logic       [16:0] exp_wide;
  logic              too_bright;
  logic              too_dark;

  assign read_ev    = tog_s != tog_seen_reg;
  assign read_y     = read_ev && (read_addr_reg == `MQER_ADDR_MOTION_Y);
  assign too_bright = (frame.pixel_peak > `MQER_PEAK_HIGH) ||
                      (frame.pixel_avg > `MQER_AVG_HIGH);
  assign too_dark   = (frame.pixel_peak < `MQER_PEAK_LOW) &&
                      (frame.pixel_avg < `MQER_AVG_LOW);

  always_comb begin
    tog_seen_next = tog_s;
    // Motion that arrives after the snapshot stays in the accumulator
    y_sum = {{2{motion_y_reg[7]}}, motion_y_reg};
    if (frame.valid) begin
      y_sum = y_sum + {{2{frame.delta_y[7]}}, frame.delta_y};
    end
    if (read_y) begin
      y_sum = y_sum - {{2{snap_reg.motion_y[7]}}, snap_reg.motion_y};
    end
    if (y_sum > 10'sd127) begin
      motion_y_next = 8'h7F;
    end else if (y_sum < -10'sd128) begin
      motion_y_next = 8'h80;
    end else begin
      motion_y_next = y_sum[7:0];
    end
    // Quality is taken from the feature count of each new frame
    q_raw        = frame.features[8:1];
    quality_next = quality_reg;
    if (frame.valid) begin
      if (q_raw > `MQER_QUALITY_MAX) begin
        quality_next = `MQER_QUALITY_MAX;
      end else begin
        quality_next = q_raw;
      end
    end
    // Exposure steps toward the pixel window once per frame
    exp_wide      = {1'b0, exposure_time};
    exposure_next = exposure_time;
    if (frame.valid && too_bright) begin
      exp_wide = exp_wide - {1'b0, `MQER_EXPOSURE_STEP};
      if (exp_wide[16] || exp_wide[15:0] < `MQER_EXPOSURE_MIN) begin
        exposure_next = `MQER_EXPOSURE_MIN;
      end else begin
        exposure_next = exp_wide[15:0];
      end
    end else if (frame.valid && too_dark) begin
      exp_wide = exp_wide + {1'b0, `MQER_EXPOSURE_STEP};
      if (exp_wide > {1'b0, `MQER_EXPOSURE_MAX}) begin
        exposure_next = `MQER_EXPOSURE_MAX;
      end else begin
        exposure_next = exp_wide[15:0];
      end
    end
    // Snapshot moves only between frames, after pending reads are settled
    snap_next = snap_reg;
    if (idle_s && !read_ev) begin
      snap_next.motion_y = motion_y_reg;
      snap_next.quality  = quality_reg;
      snap_next.exposure = exposure_time;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      motion_y_reg  <= `MQER_RST_BYTE;
      quality_reg   <= `MQER_RST_BYTE;
      exposure_time <= `MQER_RST_EXPOSURE;
      tog_seen_reg  <= 1'b0;
      snap_reg      <= '0;
    end else begin
      motion_y_reg  <= motion_y_next;
      quality_reg   <= quality_next;
      exposure_time <= exposure_next;
      tog_seen_reg  <= tog_seen_next;
      snap_reg      <= snap_next;
    end
  end

  // ========================================================================
  // Serial port, sclk domain; frame state is cleared while ncs_n is high
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [6:0] addr_sh_reg;
  logic [6:0] addr_sh_next;
  logic [7:0] data_sh_reg;
  logic [7:0] data_sh_next;
  logic       sdio_out_next;
  logic       sdio_oe_next;
  logic       read_tog_next;
  logic [6:0] read_addr_next;
  logic [7:0] exp_lo_reg;
  logic [7:0] exp_lo_next;
  logic [7:0] addr_full;
  logic [7:0] rd_data;

  always_comb begin
    addr_full      = {addr_sh_reg, sdio_in};
    bit_cnt_next   = bit_cnt_reg + 4'h1;
    addr_sh_next   = addr_sh_reg;
    data_sh_next   = {data_sh_reg[6:0], 1'b0};
    sdio_out_next  = data_sh_reg[7];
    sdio_oe_next   = sdio_oe;
    read_tog_next  = read_tog_reg;
    read_addr_next = read_addr_reg;
    exp_lo_next    = exp_lo_reg;
    rd_data        = `MQER_RST_BYTE;
    if (addr_full[6:0] == `MQER_ADDR_MOTION_Y) begin
      rd_data = snap_reg.motion_y;
    end else if (addr_full[6:0] == `MQER_ADDR_QUALITY) begin
      rd_data = snap_reg.quality;
    end else if (addr_full[6:0] == `MQER_ADDR_EXPOSURE_HI) begin
      rd_data = snap_reg.exposure[15:8];
    end else if (addr_full[6:0] == `MQER_ADDR_EXPOSURE_LO) begin
      rd_data = exp_lo_reg;
    end
    if (bit_cnt_reg < `MQER_LAST_ADDR_BIT) begin
      addr_sh_next = addr_full[6:0];
    end else if (bit_cnt_reg == `MQER_LAST_ADDR_BIT) begin
      if (!addr_full[`MQER_ADDR_WRITE_BIT]) begin
        sdio_out_next  = rd_data[7];
        data_sh_next   = {rd_data[6:0], 1'b0};
        sdio_oe_next   = 1'b1;
        read_addr_next = addr_full[6:0];
        read_tog_next  = !read_tog_reg;
        // Lower exposure byte is held from the same sample as the upper
        if (addr_full[6:0] == `MQER_ADDR_EXPOSURE_HI) begin
          exp_lo_next = snap_reg.exposure[7:0];
        end
      end
    end else if (bit_cnt_reg == `MQER_LAST_DATA_BIT) begin
      sdio_oe_next  = 1'b0;
      sdio_out_next = 1'b0;
    end
  end

  always_ff @(posedge sclk or posedge ncs_n) begin
    if (ncs_n) begin
      bit_cnt_reg <= 4'h0;
      addr_sh_reg <= 7'h00;
      data_sh_reg <= 8'h00;
      sdio_out    <= 1'b0;
      sdio_oe     <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      addr_sh_reg <= addr_sh_next;
      data_sh_reg <= data_sh_next;
      sdio_out    <= sdio_out_next;
      sdio_oe     <= sdio_oe_next;
    end
  end

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      read_tog_reg  <= 1'b0;
      read_addr_reg <= 7'h00;
      exp_lo_reg    <= `MQER_RST_BYTE;
    end else begin
      read_tog_reg  <= read_tog_next;
      read_addr_reg <= read_addr_next;
      exp_lo_reg    <= exp_lo_next;
    end
  end

  // ========================================================================
  // Checks in the core domain
  sequence s_frame_open;
    !idle_s ##1 !idle_s;
  endsequence

  sequence s_read_y_quiet;
    read_y && !frame.valid && (snap_reg.motion_y == motion_y_reg);
  endsequence

  AST_QUALITY_CAP: assert property (@(posedge clock) disable iff (!resetn)
    quality_reg <= `MQER_QUALITY_MAX)
    else $error("quality above cap");

  AST_QUALITY_SCALE: assert property (@(posedge clock) disable iff (!resetn)
    frame.valid && frame.features < 9'h100 |=>
      quality_reg == $past(q_raw))
    else $error("quality not upper feature bits");

  AST_QUALITY_EMPTY: assert property (@(posedge clock) disable iff (!resetn)
    frame.valid && frame.features < 9'h002 |=> quality_reg == 8'h00)
    else $error("quality not zero without features");

  AST_QUALITY_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    !frame.valid |=> $stable(quality_reg))
    else $error("quality changed without a frame");

  AST_EXPOSURE_DOWN: assert property (@(posedge clock) disable iff (!resetn)
    frame.valid && too_bright && exposure_time >= 16'h0020 |=>
      exposure_time == $past(exposure_time) - `MQER_EXPOSURE_STEP)
    else $error("exposure did not step down");

  AST_EXPOSURE_UP: assert property (@(posedge clock) disable iff (!resetn)
    frame.valid && !too_bright && too_dark && exposure_time <= 16'hFEF0 |=>
      exposure_time == $past(exposure_time) + `MQER_EXPOSURE_STEP)
    else $error("exposure did not step up");

  AST_SNAP_FROZEN: assert property (@(posedge clock) disable iff (!resetn)
    s_frame_open |-> $stable(snap_reg))
    else $error("snapshot moved inside a frame");

  AST_MOTION_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
    s_read_y_quiet |=> motion_y_reg == 8'h00)
    else $error("motion not cleared by read");

endmodule : mqer_readout

`default_nettype wire

// ==== verilog/mqer_consts.svh ====
// Constants of the motion, quality and exposure readout.
// Assumes inclusion by bare name from the package and the readout module.
`ifndef MQER_CONSTS_SVH
`define MQER_CONSTS_SVH

// ==========================================================================
// Register offsets on the serial port
`define MQER_ADDR_MOTION_Y     7'h04
`define MQER_ADDR_QUALITY      7'h05
`define MQER_ADDR_EXPOSURE_HI  7'h06
`define MQER_ADDR_EXPOSURE_LO  7'h07

// ==========================================================================
// Reset values, quality cap and field positions
`define MQER_RST_BYTE          8'h00
`define MQER_RST_EXPOSURE      16'h0000
`define MQER_QUALITY_MAX       8'h80
`define MQER_ADDR_WRITE_BIT    7
`define MQER_LAST_ADDR_BIT     4'h7
`define MQER_LAST_DATA_BIT     4'hF

// ==========================================================================
// Exposure control limits, in clock cycles and pixel levels
`define MQER_EXPOSURE_MIN      16'h0010
`define MQER_EXPOSURE_MAX      16'hFF00
`define MQER_EXPOSURE_STEP     16'h0010
`define MQER_PEAK_HIGH         7'h78
`define MQER_PEAK_LOW          7'h50
`define MQER_AVG_HIGH          8'hB0
`define MQER_AVG_LOW           8'h60

`endif

// ==== verilog/mqer_pkg.sv ====
// Types shared by the readout logic.
// Assumes mqer_consts.svh on the include path.
`include "mqer_consts.svh"

package mqer_pkg;

  // ========================================================================
  // Frame results from the image processor
  typedef struct packed {
    logic              valid;
    logic signed [7:0] delta_y;
    logic        [8:0] features;
    logic        [7:0] pixel_avg;
    logic        [6:0] pixel_peak;
  } mqer_frame_s;

  // ========================================================================
  // Register image frozen while a serial frame is open
  typedef struct packed {
    logic        [7:0]  motion_y;
    logic        [7:0]  quality;
    logic        [15:0] exposure;
  } mqer_snap_s;

endpackage : mqer_pkg

// ==== verilog/mqer_sync.sv ====
// Two-flop synchroniser for a group of single-bit levels.
// Assumes each bit changes at most once per two destination clocks.
`timescale 1ns/1ps
`default_nettype none

module mqer_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_out <= sync_next;
    end
  end

endmodule : mqer_sync

`default_nettype wire

// ==== verif/mqer_reader_model.sv ====
// Behavioural reader on the far side of the three-wire serial port.
// Assumes the readout samples on sclk rising and shifts out on sclk rising.
`timescale 1ns/1ps
`default_nettype none

module mqer_reader_model (
  // Serial port
  output var  logic       sclk,
  output var  logic       ncs_n,
  output wire logic       sdio_in,
  input  wire logic       sdio_out,
  input  wire logic       sdio_oe,
  // Read results
  output var  logic [7:0] rd_data,
  output var  logic       rd_valid
);
  logic drv;

  // Wire level from the readout's enable; the reader drives it otherwise
  assign sdio_in = sdio_oe ? sdio_out : drv;

  initial begin
    sclk     = 1'b1;
    ncs_n    = 1'b1;
    drv      = 1'b0;
    rd_data  = 8'h00;
    rd_valid = 1'b0;
  end

  // ==========================================================================
  // One frame of 16 rising edges; sclk stands still high outside frames
  task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata);
    logic [15:0] word;
    logic [7:0]  got;
    word  = {addr, wdata};
    got   = 8'h00;
    ncs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sclk = 1'b0;
      if (i >= 8 && !addr[7]) begin
        got[15-i] = (sdio_oe === 1'b1) ? sdio_out : 1'bx;
        // Released line does not keep its last level
        drv = ~drv;
      end else begin
        drv = word[15-i];
      end
      #62.5;
      sclk = 1'b1;
      #62.5;
    end
    // Output must already be released by the last edge of the frame
    if (sdio_oe !== 1'b0) begin
      got = 8'hXX;
    end
    ncs_n = 1'b1;
    #1;
    if (sdio_oe !== 1'b0) begin
      got = 8'hXX;
    end
    if (!addr[7]) begin
      rd_data  = got;
      rd_valid = 1'b1;
      #4;
      rd_valid = 1'b0;
    end
    #40;
  endtask : xfer
endmodule : mqer_reader_model
`default_nettype wire

// ==== verif/motion_quality_exposure_readout_bench.sv ====
// Self-checking bench of the motion, quality and exposure readout.
// Assumes the design files and mqer_consts.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "mqer_consts.svh"

module motion_quality_exposure_readout_bench
  import mqer_pkg::*;
();
  logic        clock;
  logic        resetn;
  mqer_frame_s frame;
  logic [15:0] exposure_time;
  logic        sclk;
  logic        ncs_n;
  wire  logic  sdio_in;
  logic        sdio_out;
  logic        sdio_oe;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [7:0]  expq[$];
  logic [15:0] e;
  logic [7:0]  lat;
  logic [8:0]  f;
  logic [8:0]  ftab[7] = '{9'h000, 9'h001, 9'h0FF, 9'h100, 9'h101, 9'h102,
                           9'h1FF};
  logic [7:0]  utab[5] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h7F};
  int          acc;
  int          fails;
  int          tests_run;
  integer      seed = 32'h3A45;

  mqer_readout mqer_readout_i (
    .clock(clock), .resetn(resetn), .frame(frame),
    .exposure_time(exposure_time), .sclk(sclk), .ncs_n(ncs_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe)
  );

  mqer_reader_model mqer_reader_model_i (
    .sclk(sclk), .ncs_n(ncs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .rd_data(rd_data), .rd_valid(rd_valid)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic conclude();
    if (expq.size() != 0) begin
      fails++;
      $display("wrong value at %0t: reads left unanswered", $time);
    end
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  function automatic logic [7:0] qx(input logic [8:0] fv);
    qx = (fv[8:1] > `MQER_QUALITY_MAX) ? `MQER_QUALITY_MAX : fv[8:1];
  endfunction : qx

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    expq.push_back(v);
    mqer_reader_model_i.xfer(a, 8'h00);
  endtask : rd

  task automatic rd_motion();
    rd(8'h03, 8'h00);
    rd(8'h04, 8'(acc));
    acc = 0;
  endtask : rd_motion

  // Kind 0 keeps pixels in range, 1 is dark, 2 is bright
  task automatic send(input int k, input logic [8:0] fv, input logic [7:0] d);
    @(negedge clock);
    frame = '{valid: 1'b1, delta_y: d, features: fv,
              pixel_avg: (k == 0) ? 8'h80 : (k == 1) ? 8'h10 : 8'hF0,
              pixel_peak: (k == 0) ? 7'h60 : (k == 1) ? 7'h10 : 7'h7F};
    @(negedge clock);
    frame.valid = 1'b0;
    acc = acc + $signed(d);
    acc = (acc > 127) ? 127 : (acc < -128) ? -128 : acc;
    if (k == 1) begin
      e = (e > `MQER_EXPOSURE_MAX - `MQER_EXPOSURE_STEP) ?
          `MQER_EXPOSURE_MAX : e + `MQER_EXPOSURE_STEP;
    end else if (k == 2) begin
      e = (e < `MQER_EXPOSURE_MIN + `MQER_EXPOSURE_STEP) ?
          `MQER_EXPOSURE_MIN : e - `MQER_EXPOSURE_STEP;
    end
    chk(exposure_time, e);
    repeat (3) @(negedge clock);
  endtask : send

  task automatic do_reset();
    @(negedge clock);
    resetn = 1'b0;
    repeat (16) @(negedge clock);
    resetn = 1'b1;
    e = 16'h0000;
    acc = 0;
    repeat (4) @(negedge clock);
    chk(exposure_time, 16'h0000);
    for (int a = 4; a < 8; a++) rd(8'(a), 8'h00);
  endtask : do_reset

  // ==========================================================================
  // Result watcher
  initial forever begin
    @(posedge rd_valid);
    if (expq.size() == 0) begin
      fails++;
      $display("wrong value at %0t: read without expectation", $time);
    end else begin
      chk({8'h00, rd_data}, {8'h00, expq.pop_front()});
    end
  end

  // About 100 us of serial traffic; twice that means a hang
  initial begin
    #200000;
    fails++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    frame = '0;
    resetn = 1'b0;
    fails = 0;
    tests_run = 0;
    do_reset();
    foreach (ftab[i]) begin
      send(0, ftab[i], 8'h00);
      rd(8'h05, qx(ftab[i]));
    end
    mqer_reader_model_i.xfer(8'h85, 8'hFF);
    rd(8'h05, qx(9'h1FF));
    foreach (utab[i]) rd(utab[i], 8'h00);
    send(0, 9'h000, 8'h64);
    send(0, 9'h000, 8'h64);
    rd_motion();
    rd_motion();
    send(0, 9'h000, 8'h9C);
    send(0, 9'h000, 8'h9C);
    rd_motion();
    repeat (12) begin
      f = 9'($random(seed));
      send(0, f, 8'($signed($random(seed)) >>> 28));
      rd(8'h05, qx(f));
    end
    rd_motion();
    repeat (21) send(1, 9'h000, 8'h00);
    lat = e[7:0];
    rd(8'h06, e[15:8]);
    send(1, 9'h000, 8'h00);
    rd(8'h07, lat);
    repeat (3) send(2, 9'h000, 8'h00);
    rd(8'h06, e[15:8]);
    rd(8'h07, e[7:0]);
    do_reset();
    conclude();
  end
endmodule : motion_quality_exposure_readout_bench
`default_nettype wire
